// >>> hw/mre_pkg.sv
// constants and carrier types for the move and return execution block
// assumes one core clock; instruction cycles are derived by an enable divider
package mre_pkg;

   // widths of core quantities
   typedef logic [13:0] mre_word_t;
   typedef logic [12:0] mre_pc_t;
   typedef logic [7:0]  mre_byte_t;
   typedef logic [6:0]  mre_faddr_t;

   // core clocks per instruction cycle (four phases per cycle)
   localparam int unsigned CLKS_PER_ICYCLE = 4;
   localparam logic [1:0]  DIV_LAST        = 2'(CLKS_PER_ICYCLE - 1);
   localparam logic [1:0]  DIV_RESET       = 2'h0;

   // reset values and the program counter step
   localparam mre_pc_t   PC_RESET  = 13'h0000;
   localparam mre_byte_t ACC_RESET = 8'h00;
   localparam mre_pc_t   PC_STEP   = 13'h0001;

   // opcode masks and match patterns; masked-out bits are don't-care
   localparam mre_word_t MOVE_ACC_TO_FILE_MASK   = 14'h3f80;
   localparam mre_word_t MOVE_ACC_TO_FILE_MATCH  = 14'h0080;
   localparam mre_word_t LOAD_LITERAL_ACC_MASK   = 14'h3c00;
   localparam mre_word_t LOAD_LITERAL_ACC_MATCH  = 14'h3000;
   localparam mre_word_t RETURN_WITH_LIT_MASK    = 14'h3c00;
   localparam mre_word_t RETURN_WITH_LIT_MATCH   = 14'h3400;
   localparam mre_word_t IDLE_INSTRUCTION_MASK   = 14'h3f9f;
   localparam mre_word_t IDLE_INSTRUCTION_MATCH  = 14'h0000;
   localparam mre_word_t SUB_RETURN_WORD         = 14'h0008;
   localparam mre_word_t INTERRUPT_RETURN_WORD   = 14'h0009;

   // operand fields
   localparam int unsigned LIT_LSB  = 0;
   localparam int unsigned LIT_MSB  = 7;
   localparam int unsigned FILE_LSB = 0;
   localparam int unsigned FILE_MSB = 6;

   // bit of the global_interrupt_enable inside interrupt_control_register
   localparam int unsigned GLOBAL_INTERRUPT_ENABLE_BIT = 7;

   // execution states, one-hot
   typedef enum logic [1:0] {
      ST_EXEC  = 2'h1,
      ST_FLUSH = 2'h2
   } mre_state_e;

   // file register write port
   typedef struct packed {
      logic   we;
      mre_faddr_t addr;
      mre_byte_t  data;
   } mre_file_wr_s;

   // divider state
   typedef struct packed {
      logic [1:0] cnt;
      logic       en;
   } mre_div_s;

   // execution core state
   typedef struct packed {
      mre_state_e   state;
      mre_pc_t      pc;
      mre_byte_t    acc;
      mre_file_wr_s fwr;
      logic         pop;
      logic         int_enable_set;
      logic         done;
      logic         unsupported;
   } mre_core_s;

endpackage

// >>> hw/mre_cycle_div.sv
// instruction cycle enable divider
// assumes the core clock; gives a one-clock pulse once per instruction cycle
`timescale 1ns/100ps

module mre_cycle_div (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // instruction cycle enable
   output logic      en_o
);

   mre_pkg::mre_div_s div_r;
   mre_pkg::mre_div_s div_nxt;

   // count phases; pulse in the clock after the last one
   always_comb begin
      div_nxt     = div_r;
      div_nxt.en  = (div_r.cnt == mre_pkg::DIV_LAST);
      div_nxt.cnt = (div_r.cnt == mre_pkg::DIV_LAST) ? mre_pkg::DIV_RESET
                                                      : div_r.cnt + 2'h1;
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   assign en_o = div_r.en;

endmodule // mre_cycle_div

// >>> hw/mre_exec_core.sv
// executes accumulator moves, literal loads, the idle instruction and the returns
// assumes program memory and return stack on the same clock; the word at
// PROG_ADDR_O and the stack top are stable by the end of each instruction cycle
`timescale 1ns/100ps

// What this block does
// - move accumulator into addressed file register, one cycle
// - load eight-bit literal into accumulator, one cycle
// - interrupt return pops stack into PC, two cycles
// - interrupt return sets global interrupt enable bit
// - literal return loads literal into accumulator
// - literal return reloads PC from stack, two cycles
// - subroutine return pops stack into PC, two cycles
module mre_exec_core (
   // clock and reset
   input  wire logic                 CLOCK_I,
   input  wire logic                 RESET_N_I,
   // program memory
   input  wire mre_pkg::mre_word_t   PROG_WORD_I,
   output mre_pkg::mre_pc_t          PROG_ADDR_O,
   // return stack
   input  wire mre_pkg::mre_pc_t     TOP_OF_STACK_I,
   output logic                      STACK_POP_O,
   // data side
   output mre_pkg::mre_byte_t        ACC_O,
   output mre_pkg::mre_file_wr_s     FILE_WR_O,
   output logic                      GLOBAL_INTERRUPT_ENABLE_SET_O,
   // progress
   output logic                      CYCLE_DONE_O,
   output logic                      UNSUPPORTED_O
);

   logic                 icyc_en;
   mre_pkg::mre_core_s   core_r;
   mre_pkg::mre_core_s   core_nxt;
   mre_pkg::mre_byte_t   lit;
   mre_pkg::mre_faddr_t  faddr;
   logic                 is_store;
   logic                 is_load;
   logic                 is_lit_ret;
   logic                 is_idle;
   logic                 is_sub_ret;
   logic                 is_int_ret;

   // instruction cycle timing
   mre_cycle_div u_div (
      .clk_i   (CLOCK_I),
      .rst_n_i (RESET_N_I),
      .en_o    (icyc_en)
   );

   // decode; don't-care bits are masked, not checked
   assign lit       = PROG_WORD_I[mre_pkg::LIT_MSB:mre_pkg::LIT_LSB];
   assign faddr     = PROG_WORD_I[mre_pkg::FILE_MSB:mre_pkg::FILE_LSB];
   assign is_store   = (PROG_WORD_I & mre_pkg::MOVE_ACC_TO_FILE_MASK)
                       == mre_pkg::MOVE_ACC_TO_FILE_MATCH;
   assign is_load    = (PROG_WORD_I & mre_pkg::LOAD_LITERAL_ACC_MASK)
                       == mre_pkg::LOAD_LITERAL_ACC_MATCH;
   assign is_lit_ret = (PROG_WORD_I & mre_pkg::RETURN_WITH_LIT_MASK)
                       == mre_pkg::RETURN_WITH_LIT_MATCH;
   assign is_idle    = (PROG_WORD_I & mre_pkg::IDLE_INSTRUCTION_MASK)
                       == mre_pkg::IDLE_INSTRUCTION_MATCH;
   assign is_sub_ret = PROG_WORD_I == mre_pkg::SUB_RETURN_WORD;
   assign is_int_ret = PROG_WORD_I == mre_pkg::INTERRUPT_RETURN_WORD;

   // next state; pulses last one clock, at the end of the instruction cycle
   always_comb begin
      core_nxt             = core_r;
      core_nxt.fwr.we      = 1'b0;
      core_nxt.pop         = 1'b0;
      core_nxt.int_enable_set = 1'b0;
      core_nxt.done        = 1'b0;
      core_nxt.unsupported = 1'b0;
      if (icyc_en) begin
         core_nxt.done = 1'b1;
         case (core_r.state)
            mre_pkg::ST_EXEC: begin
               // default path: advance by one word
               core_nxt.pc = core_r.pc + mre_pkg::PC_STEP;
               if (is_store) begin
                  core_nxt.fwr.we   = 1'b1;
                  core_nxt.fwr.addr = faddr;
                  core_nxt.fwr.data = core_r.acc;
               end else if (is_load) begin
                  core_nxt.acc = lit;
               end else if (is_lit_ret) begin
                  core_nxt.acc   = lit;
                  core_nxt.pc    = TOP_OF_STACK_I;
                  core_nxt.pop   = 1'b1;
                  core_nxt.state = mre_pkg::ST_FLUSH;
               end else if (is_sub_ret) begin
                  core_nxt.pc    = TOP_OF_STACK_I;
                  core_nxt.pop   = 1'b1;
                  core_nxt.state = mre_pkg::ST_FLUSH;
               end else if (is_int_ret) begin
                  core_nxt.pc             = TOP_OF_STACK_I;
                  core_nxt.pop            = 1'b1;
                  core_nxt.int_enable_set = 1'b1;
                  core_nxt.state          = mre_pkg::ST_FLUSH;
               end else if (is_idle) begin
                  core_nxt.pc = core_r.pc + mre_pkg::PC_STEP;
               end else begin
                  // other opcodes belong elsewhere; skipped like idle
                  core_nxt.unsupported = 1'b1;
               end
            end
            mre_pkg::ST_FLUSH: begin
               // second cycle of a return: the fetched word is discarded
               core_nxt.state = mre_pkg::ST_EXEC;
            end
            default: begin
               core_nxt.state = mre_pkg::ST_EXEC;
            end
         endcase
      end
   end

   // state register; no status flags are kept or touched here
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         core_r.state       <= mre_pkg::ST_EXEC;
         core_r.pc          <= mre_pkg::PC_RESET;
         core_r.acc         <= mre_pkg::ACC_RESET;
         core_r.fwr         <= '0;
         core_r.pop         <= 1'b0;
         core_r.int_enable_set <= 1'b0;
         core_r.done        <= 1'b0;
         core_r.unsupported <= 1'b0;
      end else begin
         core_r <= core_nxt;
      end
   end

   // outputs straight from the state register
   assign PROG_ADDR_O   = core_r.pc;
   assign ACC_O         = core_r.acc;
   assign FILE_WR_O     = core_r.fwr;
   assign STACK_POP_O   = core_r.pop;
   assign GLOBAL_INTERRUPT_ENABLE_SET_O = core_r.int_enable_set;
   assign CYCLE_DONE_O  = core_r.done;
   assign UNSUPPORTED_O = core_r.unsupported;

endmodule // mre_exec_core

// >>> tb/mre_prog_model.sv
// program memory model answering at the program counter
// assumes the bench writes each word before it is sampled
`timescale 1ns/100ps
module mre_prog_model (
   // fetch side
   input  wire mre_pkg::mre_pc_t addr_i,
   output mre_pkg::mre_word_t    word_o
);
   mre_pkg::mre_word_t mem [0:8191];
   // asynchronous read; unwritten words stay unknown on purpose
   assign word_o = mem[addr_i];
endmodule // mre_prog_model

// >>> tb/mre_exec_core_monitor.sv
// checker for the move and return execution block
// assumes binding onto mre_exec_core; sees its ports only
`timescale 1ns/100ps
module mre_exec_core_monitor (
   // clock and reset
   input wire logic                  CLOCK_I,
   input wire logic                  RESET_N_I,
   // watched ports
   input wire mre_pkg::mre_word_t    PROG_WORD_I,
   input wire mre_pkg::mre_pc_t      PROG_ADDR_O,
   input wire mre_pkg::mre_pc_t      TOP_OF_STACK_I,
   input wire logic                  STACK_POP_O,
   input wire mre_pkg::mre_byte_t    ACC_O,
   input wire mre_pkg::mre_file_wr_s FILE_WR_O,
   input wire logic                  GLOBAL_INTERRUPT_ENABLE_SET_O,
   input wire logic                  CYCLE_DONE_O,
   input wire logic                  UNSUPPORTED_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   // one instruction cycle is four clocks
   done_spacing_a: assert property (CYCLE_DONE_O |=> !CYCLE_DONE_O [*3] ##1 CYCLE_DONE_O)
      else $error("cycle done spacing wrong");
   store_write_a: assert property (FILE_WR_O.we |-> FILE_WR_O.data == $past(ACC_O)
      && FILE_WR_O.addr == $past(PROG_WORD_I[6:0])) else $error("file write wrong");
   load_lit_a: assert property (CYCLE_DONE_O && $past(PROG_WORD_I[13:10]) == 4'hc
      && PROG_ADDR_O == 13'($past(PROG_ADDR_O) + 13'h1) |-> ACC_O == $past(PROG_WORD_I[7:0]))
      else $error("literal load wrong");
   pop_jump_a: assert property (STACK_POP_O |-> CYCLE_DONE_O
      && PROG_ADDR_O == $past(TOP_OF_STACK_I)) else $error("return target wrong");
   ret_flush_a: assert property (STACK_POP_O |=> (!STACK_POP_O && $stable(PROG_ADDR_O)) [*4])
      else $error("return not two cycles");
   enable_set_a: assert property (GLOBAL_INTERRUPT_ENABLE_SET_O |-> STACK_POP_O
      && $past(PROG_WORD_I) == 14'h0009) else $error("enable set wrong");
   lit_return_a: assert property (STACK_POP_O && $past(PROG_WORD_I[13:10]) == 4'hd
      |-> ACC_O == $past(PROG_WORD_I[7:0])) else $error("return literal wrong");
   quiet_between_a: assert property (!CYCLE_DONE_O |-> $stable(ACC_O) && $stable(PROG_ADDR_O))
      else $error("state moved off cycle");
   unknown_idle_a: assert property (UNSUPPORTED_O |-> !FILE_WR_O.we && $stable(ACC_O)
      && PROG_ADDR_O == 13'($past(PROG_ADDR_O) + 13'h1)) else $error("unknown word acted");
endmodule // mre_exec_core_monitor
bind mre_exec_core mre_exec_core_monitor mon_u (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
   .PROG_WORD_I(PROG_WORD_I), .PROG_ADDR_O(PROG_ADDR_O), .TOP_OF_STACK_I(TOP_OF_STACK_I),
   .ACC_O(ACC_O), .STACK_POP_O(STACK_POP_O), .FILE_WR_O(FILE_WR_O),
   .GLOBAL_INTERRUPT_ENABLE_SET_O(GLOBAL_INTERRUPT_ENABLE_SET_O),
   .CYCLE_DONE_O(CYCLE_DONE_O), .UNSUPPORTED_O(UNSUPPORTED_O));

// >>> tb/tb.sv
// self-checking bench for the move and return execution block
// assumes the program memory model and the bound checker
`timescale 1ns/100ps
module tb;
   logic CLOCK_I = 1'b0;
   logic RESET_N_I = 1'b0;
   logic pop, ie_set, done, uns, flush = 1'b0;
   mre_pkg::mre_word_t word;
   mre_pkg::mre_pc_t pc_o, stack_top = 13'h0000, e_pc = 13'h0000;
   mre_pkg::mre_byte_t acc, e_acc = 8'h00, e_data = 8'h00;
   mre_pkg::mre_faddr_t e_addr = 7'h00;
   mre_pkg::mre_file_wr_s fwr;
   logic [39:0] exp_q [$];
   int bad_count = 0;
   int check_count = 0;
   logic [31:0] seed = 32'd62714;
   mre_exec_core dut_u (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .PROG_WORD_I(word),
      .PROG_ADDR_O(pc_o), .TOP_OF_STACK_I(stack_top), .STACK_POP_O(pop), .ACC_O(acc),
      .FILE_WR_O(fwr), .GLOBAL_INTERRUPT_ENABLE_SET_O(ie_set), .CYCLE_DONE_O(done),
      .UNSUPPORTED_O(uns));
   mre_prog_model m_u (.addr_i(pc_o), .word_o(word));
   always #4 CLOCK_I = ~CLOCK_I;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // place the next word at the expected pc and note what it must do
   task automatic plan();
      logic [31:0] r;
      mre_pkg::mre_word_t w;
      mre_pkg::mre_pc_t t;
      logic [3:0] f;
      r = rnd();
      // stack top for this word; it must stand until the word is taken
      t = 13'(rnd() >> 19);
      f = 4'h0;
      w = 14'h3000 | 14'(r[7:0]);
      if (!flush) begin
         case (3'(r[15:0] % 16'd7))
            3'h0: begin
               w = 14'h0080 | 14'(r[6:0]);
               f = 4'h8;
               e_addr = r[6:0];
               e_data = e_acc;
            end
            3'h1: e_acc = r[7:0];
            3'h2: w = 14'(r[6:5]) << 5;
            3'h3: w = 14'h0008;
            3'h4: w = 14'h3400 | 14'(r[7:0]);
            3'h5: w = 14'h0009;
            default: begin
               w = 14'h3800 | 14'(r[9:0]);
               f = 4'h1;
            end
         endcase
      end
      m_u.mem[e_pc] <= w;
      // returns jump to the stack top and burn one discarded cycle
      if (!flush && (w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hd)) begin
         f = (w == 14'h0009) ? 4'h6 : 4'h4;
         e_acc = (w[13:10] == 4'hd) ? w[7:0] : e_acc;
         e_pc = t;
         flush = 1'b1;
      end
      else if (flush)
         flush = 1'b0;
      else
         e_pc = e_pc + 13'h0001;
      exp_q.push_back({e_pc, e_acc, f[3], e_addr, e_data, f[2:0]});
      stack_top <= t;
   endtask
   // compare every instruction cycle result with the oldest note
   always @(posedge CLOCK_I iff done) begin
      check({pc_o, acc, fwr, pop, ie_set, uns}, exp_q.pop_front());
   end
   initial begin
      plan();
      repeat (10) @(posedge CLOCK_I);
      RESET_N_I <= 1'b1;
      repeat (300) begin
         @(posedge CLOCK_I iff done);
         plan();
      end
      @(posedge CLOCK_I iff done);
      @(posedge CLOCK_I);
      conclude();
   end
   // about twice the expected run length
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
endmodule // tb
